// *** pkg/dma_trig_map.svh ***
// Register offsets, field positions, reset values and codes for the DMA trigger/interrupt block.
// Assumes a Wishbone slave with 32-bit data and byte addresses.
`ifndef DMA_TRIG_MAP_SVH
`define DMA_TRIG_MAP_SVH
`define OFS_TRIG_SEL0    8'h00
`define OFS_TRIG_SEL1    8'h04
`define OFS_RT_TRIG_SEL  8'h08
`define OFS_CH_CONFIG    8'h0C
`define OFS_CH_STATUS    8'h10
`define OFS_RT_CONFIG    8'h14
`define OFS_RT_STATUS    8'h18
`define OFS_IRQ_STATUS   8'h1C
`define OFS_IRQ_MASK     8'h20
`define OFS_CH_CTRL      8'h24
`define OFS_AREA_SIZE    8'h28
`define OFS_BASE_ADDR    8'h2C
`define OFS_CUR_ADDR     8'h30
`define OFS_EVENT_IN     8'h34
`define SRC_EXT0         7'h01
`define SRC_EXT1         7'h02
`define SRC_RT_EXT       7'h03
`define BIT_DETECT_MASK  0
`define BIT_OUTPUT_MASK  0
`define BIT_CH_PEND      1
`define IRQ_CH           0
`define IRQ_RT           1
`define IRQ_BUSERR       2
`define IRQ_WIDTH        3
`define RESET_WORD       32'h0000_0000
`endif

// *** pkg/dma_trig_pkg.sv ***
// Types shared by the DMA trigger/interrupt block.
// Constants live in dma_trig_map.svh.
package dma_trig_pkg;
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } wb_req_s;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BURST = 3'b010,
    ST_SKIP  = 3'b100
  } walk_e;
endpackage

// *** rtl/dma_trig_irq.sv ***
// DMA trigger selection, skip-space address stepping and interrupt generation.
// Assumes a classic Wishbone master, synchronous request pins, one clock.
// Notes on behaviour
// - Areas take separate continuous and skip sizes; skip follows each continuous run.
// - Trigger code 01H picks input 0, 02H input 1, 03H the real-time input.
// - Each external input triggers only through its own select register.
// - Completion raises channel interrupt unless detection mask or output mask is one.
// - Invalid link descriptor raises channel interrupt unless its descriptor mask or output mask is one.
// - Bus error response raises the bus-error interrupt, with no masks applied.
`timescale 1ns/100ps
`include "dma_trig_map.svh"
module dma_trig_irq
  import dma_trig_pkg::*;
#(
  parameter int AW = 32
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic [7:0]    adr_i,
  input  wire logic [31:0]   dat_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic          we_i,
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  output logic [31:0]        dat_o,
  output logic               ack_o,
  input  wire logic          ext_request_in0_n_i,
  input  wire logic          ext_request_in1_n_i,
  input  wire logic          rt_ext_request_in_n_i,
  input  wire logic          xfer_done_i,
  input  wire logic          rt_xfer_done_i,
  input  wire logic          desc_invalid_i,
  input  wire logic          descriptor_invalid_mask_i,
  input  wire logic          rt_desc_invalid_i,
  input  wire logic          rt_descriptor_invalid_mask_i,
  input  wire logic          bus_err_resp_i,
  output logic               trigger_o,
  output logic               rt_trigger_o,
  output logic [AW-1:0]      access_addr_o,
  output logic               access_valid_o,
  output logic               channel_irq_o,
  output logic               rt_channel_irq_o,
  output logic               bus_error_irq_o,
  output logic               irq_o
);
  wb_req_s       req;
  logic [31:0]   trigger_select_reg;
  logic [31:0]   trigger_select_reg1;
  logic [31:0]   rt_trigger_select_reg;
  logic [31:0]   channel_config_reg;
  logic [31:0]   channel_status_reg;
  logic [31:0]   rt_channel_config_reg;
  logic [31:0]   rt_channel_status_reg;
  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask;
  logic [31:0]   area_size;
  logic [AW-1:0] base_addr;
  logic          run_en;
  logic          ch_pend;
  logic          rt_pend;
  logic          wr_hit;
  logic          ch_event;
  logic          rt_event;
  logic [`IRQ_WIDTH-1:0] ev_vec;
  logic [15:0]   run_cnt;
  logic [15:0]   skip_cnt;
  logic [AW-1:0] walk_addr;
  logic          ch_out_mask;
  logic          rt_out_mask;
  walk_e         walk;
  logic [31:0]   next_dat;
  logic          req0;
  logic          req1;
  logic          reqrt;

  assign req = '{adr: adr_i, dat: dat_i, sel: sel_i, we: we_i, cyc: cyc_i, stb: stb_i};
  assign wr_hit = req.cyc & req.stb & req.we & ~ack_o & ce_i;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Code match: a source fires only from the register that owns it
  function automatic logic src_hit(input logic [31:0] selreg, input logic [6:0] code);
    return selreg[6:0] == code;
  endfunction

  assign req0  = ~ext_request_in0_n_i;
  assign req1  = ~ext_request_in1_n_i;
  assign reqrt = ~rt_ext_request_in_n_i;

  // Select register 1 ignores code 01H, register 0 ignores 02H
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trigger_o    <= 1'b0;
      rt_trigger_o <= 1'b0;
    end else if (ce_i) begin
      trigger_o    <= (src_hit(trigger_select_reg, `SRC_EXT0) & req0) |
                      (src_hit(trigger_select_reg1, `SRC_EXT1) & req1);
      rt_trigger_o <= src_hit(rt_trigger_select_reg, `SRC_RT_EXT) & reqrt;
    end
  end

  // Register writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trigger_select_reg    <= `RESET_WORD;
      trigger_select_reg1   <= `RESET_WORD;
      rt_trigger_select_reg <= `RESET_WORD;
      channel_config_reg    <= `RESET_WORD;
      rt_channel_config_reg <= `RESET_WORD;
      irq_mask              <= '0;
      area_size             <= `RESET_WORD;
      base_addr             <= '0;
      run_en                <= 1'b0;
      ch_out_mask           <= 1'b0;
      rt_out_mask           <= 1'b0;
    end else if (wr_hit) begin
      unique case (req.adr)
        `OFS_TRIG_SEL0:   trigger_select_reg    <= merge(trigger_select_reg, req.dat, req.sel);
        `OFS_TRIG_SEL1:   trigger_select_reg1   <= merge(trigger_select_reg1, req.dat, req.sel);
        `OFS_RT_TRIG_SEL: rt_trigger_select_reg <= merge(rt_trigger_select_reg, req.dat, req.sel);
        `OFS_CH_CONFIG:   channel_config_reg    <= merge(channel_config_reg, req.dat, req.sel);
        `OFS_RT_CONFIG:   rt_channel_config_reg <= merge(rt_channel_config_reg, req.dat, req.sel);
        `OFS_CH_STATUS: begin
          if (req.sel[0]) begin
            ch_out_mask <= req.dat[`BIT_OUTPUT_MASK];
          end
        end
        `OFS_RT_STATUS: begin
          if (req.sel[0]) begin
            rt_out_mask <= req.dat[`BIT_OUTPUT_MASK];
          end
        end
        `OFS_IRQ_MASK: begin
          if (req.sel[0]) begin
            irq_mask <= req.dat[`IRQ_WIDTH-1:0];
          end
        end
        `OFS_CH_CTRL: begin
          if (req.sel[0]) begin
            run_en <= req.dat[0];
          end
        end
        `OFS_AREA_SIZE:   area_size <= merge(area_size, req.dat, req.sel);
        `OFS_BASE_ADDR:   base_addr <= AW'(merge(32'(base_addr), req.dat, req.sel));
        default: ;
      endcase
    end
  end
  assign channel_status_reg    = {30'h0, ch_pend, ch_out_mask};
  assign rt_channel_status_reg = {30'h0, rt_pend, rt_out_mask};

  // Detection masks stop the pending bit; descriptor mask gates invalid events
  assign ch_event = (xfer_done_i & ~channel_config_reg[`BIT_DETECT_MASK]) |
                    (desc_invalid_i & ~descriptor_invalid_mask_i);
  assign rt_event = (rt_xfer_done_i & ~rt_channel_config_reg[`BIT_DETECT_MASK]) |
                    (rt_desc_invalid_i & ~rt_descriptor_invalid_mask_i);
  assign ev_vec = {bus_err_resp_i, rt_event, ch_event};

  // Set wins over write-one-to-clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch_pend    <= 1'b0;
      rt_pend    <= 1'b0;
      irq_status <= '0;
    end else if (ce_i) begin
      if (ch_event) begin
        ch_pend <= 1'b1;
      end else if (wr_hit && req.adr == `OFS_CH_STATUS && req.sel[0] && req.dat[`BIT_CH_PEND]) begin
        ch_pend <= 1'b0;
      end
      if (rt_event) begin
        rt_pend <= 1'b1;
      end else if (wr_hit && req.adr == `OFS_RT_STATUS && req.sel[0] && req.dat[`BIT_CH_PEND]) begin
        rt_pend <= 1'b0;
      end
      if (wr_hit && req.adr == `OFS_IRQ_STATUS && req.sel[0]) begin
        irq_status <= (irq_status & ~req.dat[`IRQ_WIDTH-1:0]) | ev_vec;
      end else begin
        irq_status <= irq_status | ev_vec;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      channel_irq_o    <= 1'b0;
      rt_channel_irq_o <= 1'b0;
      bus_error_irq_o  <= 1'b0;
      irq_o            <= 1'b0;
    end else if (ce_i) begin
      channel_irq_o    <= ch_pend & ~channel_status_reg[`BIT_OUTPUT_MASK];
      rt_channel_irq_o <= rt_pend & ~rt_channel_status_reg[`BIT_OUTPUT_MASK];
      bus_error_irq_o  <= bus_err_resp_i;
      irq_o            <= |(irq_status & ~irq_mask);
    end
  end

  // Skip-space walk: area_size[15:0] continuous words, [31:16] skipped words
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      walk           <= ST_IDLE;
      run_cnt        <= 16'h0000;
      skip_cnt       <= 16'h0000;
      walk_addr      <= '0;
      access_addr_o  <= '0;
      access_valid_o <= 1'b0;
    end else if (ce_i) begin
      access_valid_o <= 1'b0;
      unique case (walk)
        ST_IDLE: begin
          if (run_en && area_size[15:0] != 16'h0000) begin
            walk          <= ST_BURST;
            walk_addr     <= base_addr;
            run_cnt       <= 16'h0000;
          end
        end
        ST_BURST: begin
          if (!run_en) begin
            walk <= ST_IDLE;
          end else if (trigger_o || rt_trigger_o) begin
            access_valid_o <= 1'b1;
            access_addr_o  <= walk_addr;
            walk_addr      <= walk_addr + AW'(4);
            if (run_cnt + 16'h0001 == area_size[15:0]) begin
              run_cnt  <= 16'h0000;
              skip_cnt <= area_size[31:16];
              walk     <= (area_size[31:16] == 16'h0000) ? ST_BURST : ST_SKIP;
            end else begin
              run_cnt <= run_cnt + 16'h0001;
            end
          end
        end
        ST_SKIP: begin
          // One skipped word per cycle keeps the adder narrow
          walk_addr     <= walk_addr + AW'(4);
          skip_cnt      <= skip_cnt - 16'h0001;
          if (skip_cnt == 16'h0001) begin
            walk <= ST_BURST;
          end
        end
      endcase
    end
  end

  always_comb begin
    next_dat = 32'h0000_0000;
    unique case (req.adr)
      `OFS_TRIG_SEL0:   next_dat = trigger_select_reg;
      `OFS_TRIG_SEL1:   next_dat = trigger_select_reg1;
      `OFS_RT_TRIG_SEL: next_dat = rt_trigger_select_reg;
      `OFS_CH_CONFIG:   next_dat = channel_config_reg;
      `OFS_CH_STATUS:   next_dat = channel_status_reg;
      `OFS_RT_CONFIG:   next_dat = rt_channel_config_reg;
      `OFS_RT_STATUS:   next_dat = rt_channel_status_reg;
      `OFS_IRQ_STATUS:  next_dat = {29'h0, irq_status};
      `OFS_IRQ_MASK:    next_dat = {29'h0, irq_mask};
      `OFS_CH_CTRL:     next_dat = {31'h0, run_en};
      `OFS_AREA_SIZE:   next_dat = area_size;
      `OFS_BASE_ADDR:   next_dat = 32'(base_addr);
      `OFS_CUR_ADDR:    next_dat = 32'(access_addr_o);
      `OFS_EVENT_IN:    next_dat = {29'h0, reqrt, req1, req0};
      default:          next_dat = 32'h0000_0000;
    endcase
  end

  // Unmapped addresses ack with zero rather than stall the bus
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= req.cyc & req.stb & ~ack_o;
      dat_o <= next_dat;
    end
  end

  trig_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req1 && src_hit(trigger_select_reg, `SRC_EXT1) && !src_hit(trigger_select_reg1, `SRC_EXT1)
    && !(src_hit(trigger_select_reg, `SRC_EXT0) && req0) |=> !trigger_o)
    else $error("input 1 fired through wrong select register");
  trig_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && reqrt && src_hit(rt_trigger_select_reg, `SRC_RT_EXT) |=> rt_trigger_o)
    else $error("real-time trigger missed");
  done_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && xfer_done_i && !channel_config_reg[0] && !channel_status_reg[0] && !wr_hit
    ##1 ce_i && !wr_hit && !channel_status_reg[0] |=> channel_irq_o)
    else $error("completion interrupt missing");
  det_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !ch_pend && !ch_event |=> !ch_pend)
    else $error("pending set without event");
  out_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && channel_status_reg[0] |=> !channel_irq_o)
    else $error("output mask ignored");
  desc_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && desc_invalid_i && !descriptor_invalid_mask_i |=> ch_pend)
    else $error("invalid descriptor not flagged");
  bus_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && bus_err_resp_i |=> bus_error_irq_o && irq_status[`IRQ_BUSERR])
    else $error("bus error interrupt missing");
  skip_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && walk == ST_SKIP |=> walk_addr == $past(walk_addr) + AW'(4) || !ce_i)
    else $error("skip did not advance address");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  skip_c: cover property (@(posedge clk_i) disable iff (rst_i) walk == ST_SKIP ##1 walk == ST_BURST);
  irq_c: cover property (@(posedge clk_i) disable iff (rst_i) channel_irq_o && bus_error_irq_o);
  trig_c: cover property (@(posedge clk_i) disable iff (rst_i) trigger_o ##1 rt_trigger_o);
endmodule

// *** verif/req_src_model.sv ***
// Model of the request pins and bus-side event sources around the trigger block.
// Assumes the bench commands levels and pulses just after a rising edge.
`timescale 1ns/100ps
module req_src_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] want_i,
  input  wire logic [4:0] fire_i,
  output logic      [2:0] req_n_o,
  output logic      [4:0] pulse_o
);
  // Requests move only on the clock edge, so the block never samples a glitch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_n_o <= 3'h7;
      pulse_o <= 5'h00;
    end else begin
      req_n_o <= ~want_i;
      pulse_o <= fire_i;
    end
  end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the trigger/interrupt block over classic Wishbone.
// Assumes the register map header and a one-cycle registered ack.
`timescale 1ns/100ps
`include "dma_trig_map.svh"
module testbench;
  import dma_trig_pkg::*;
  logic        clk_i, rst_i, ce_i, we_i, cyc_i, stb_i, descriptor_invalid_mask, rt_dim, chirq;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic [3:0]  sel_i;
  logic [2:0]  want, req_n;
  logic [4:0]  fire, pulse;
  logic        ack_o, trigger_o, rt_trigger_o, access_valid_o;
  logic        channel_irq_o, rt_channel_irq_o, bus_error_irq_o, irq_o;
  logic [31:0] access_addr_o;
  logic [7:0]  ofs [3];
  int          bad_count, check_count, i, n;
  dma_trig_irq dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o), .ext_request_in0_n_i(req_n[0]),
    .ext_request_in1_n_i(req_n[1]), .rt_ext_request_in_n_i(req_n[2]),
    .xfer_done_i(pulse[0]), .rt_xfer_done_i(pulse[1]), .desc_invalid_i(pulse[2]),
    .descriptor_invalid_mask_i(descriptor_invalid_mask), .rt_desc_invalid_i(pulse[3]),
    .rt_descriptor_invalid_mask_i(rt_dim), .bus_err_resp_i(pulse[4]),
    .trigger_o(trigger_o), .rt_trigger_o(rt_trigger_o), .access_addr_o(access_addr_o),
    .access_valid_o(access_valid_o), .channel_irq_o(channel_irq_o),
    .rt_channel_irq_o(rt_channel_irq_o), .bus_error_irq_o(bus_error_irq_o), .irq_o(irq_o));
  req_src_model src_u (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .fire_i(fire),
    .req_n_o(req_n), .pulse_o(pulse));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until ack is seen; only the watchdog limits the wait
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
  initial begin
    {rst_i, ce_i, we_i, cyc_i, stb_i, descriptor_invalid_mask, rt_dim} = 7'b1100000;
    {adr_i, dat_i, want, fire} = '0;
    sel_i = 4'hF;
    ofs = '{`OFS_TRIG_SEL0, `OFS_TRIG_SEL1, `OFS_RT_TRIG_SEL};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_TRIG_SEL0, `RESET_WORD);
    rd(`OFS_IRQ_STATUS, `RESET_WORD);
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0000_0000);
    $display("reset and map test done");
    // Every code into every select register against every pin
    for (int r = 0; r < 3; r++) for (int c = 1; c < 4; c++) begin
      wb(1'b1, ofs[r], c);
      rd(ofs[r], c);
      for (int k = 0; k < 3; k++) begin
        want <= 3'h1 << k;
        settle(4);
        chk(trigger_o, (r == 0 && c == 1 && k == 0) || (r == 1 && c == 2 && k == 1));
        chk(rt_trigger_o, r == 2 && c == 3 && k == 2);
      end
      want <= 3'h0;
      wb(1'b1, ofs[r], 32'h0);
    end
    $display("trigger select test done");
    // Completion and invalid descriptor, both controllers, all mask mixes
    for (int ctl = 0; ctl < 2; ctl++) for (int kd = 0; kd < 2; kd++)
      for (int m = 0; m < 4; m++) begin
        wb(1'b1, ctl ? `OFS_RT_CONFIG : `OFS_CH_CONFIG, kd ? 0 : m & 1);
        wb(1'b1, ctl ? `OFS_RT_STATUS : `OFS_CH_STATUS, m >> 1);
        descriptor_invalid_mask <= kd && !ctl && m[0];
        rt_dim <= kd && ctl && m[0];
        @(posedge clk_i);
        fire <= 5'h01 << (ctl + 2 * kd);
        @(posedge clk_i);
        fire <= 5'h00;
        settle(4);
        chirq = ctl ? rt_channel_irq_o : channel_irq_o;
        chk(chirq, m == 0);
        chk(irq_o, !m[0]);
        wb(1'b1, ctl ? `OFS_RT_STATUS : `OFS_CH_STATUS, 32'h2);
        wb(1'b1, `OFS_IRQ_STATUS, 32'h7);
        settle(3);
        chk(irq_o, 1'b0);
        chk(ctl ? rt_channel_irq_o : channel_irq_o, 1'b0);
      end
    $display("channel interrupt test done");
    // Bus error ignores every channel mask
    wb(1'b1, `OFS_CH_CONFIG, 32'h1);
    wb(1'b1, `OFS_CH_STATUS, 32'h1);
    wb(1'b1, `OFS_IRQ_MASK, 32'h4);
    @(posedge clk_i);
    fire <= 5'h10;
    @(posedge clk_i);
    fire <= 5'h00;
    settle(1);
    chk(bus_error_irq_o, 1'b1);
    settle(3);
    chk(irq_o, 1'b0);
    rd(`OFS_IRQ_STATUS, 32'h4);
    wb(1'b1, `OFS_IRQ_MASK, 32'h0);
    settle(3);
    chk(irq_o, 1'b1);
    wb(1'b1, `OFS_IRQ_STATUS, 32'h4);
    $display("bus error test done");
    // Two continuous words then one skipped word
    wb(1'b1, `OFS_AREA_SIZE, 32'h0001_0002);
    wb(1'b1, `OFS_BASE_ADDR, 32'h0000_0100);
    wb(1'b1, `OFS_TRIG_SEL0, 32'h1);
    want <= 3'h1;
    wb(1'b1, `OFS_CH_CTRL, 32'h1);
    i = 0;
    n = 0;
    while (i < 4 && n < 200) begin
      settle(1);
      n++;
      if (access_valid_o === 1'b1) begin
        chk(access_addr_o, 32'h100 + 4 * (i + i / 2));
        i++;
      end
    end
    chk(i, 4);
    want <= 3'h0;
    wb(1'b1, `OFS_CH_CTRL, 32'h0);
    $display("skip walk test done");
    test_done();
  end
endmodule
